// *** verilog/orient_pkg.sv ***
// orientation detection block: register map, field layout, reset values, states
// assumes one system clock and a synchronous active-high reset
package orient_pkg;
  // register offsets
  localparam logic [7:0] ADDR_STATE = 8'h28;
  localparam logic [7:0] ADDR_SETUP = 8'h29;
  localparam logic [7:0] ADDR_DBCOUNT = 8'h2A;
  // orientation_state_register fields
  localparam int FLAG_BIT = 7;
  localparam int TILT_BIT = 6;
  localparam int LP_HI = 2;
  localparam int LP_LO = 1;
  localparam int BF_BIT = 0;
  // orientation_setup_register fields
  localparam int MODE_BIT = 7;
  localparam int ENABLE_BIT = 6;
  // reset values
  localparam logic [7:0] STATE_RESET = 8'h00;
  localparam logic [7:0] SETUP_RESET = 8'h80;
  localparam logic [7:0] DBCOUNT_RESET = 8'h00;
  // landscape/portrait and back/front encodings
  localparam logic [1:0] LP_PORTRAIT_UP = 2'h0;
  localparam logic [1:0] LP_PORTRAIT_DOWN = 2'h1;
  localparam logic [1:0] LP_LANDSCAPE_RIGHT = 2'h2;
  localparam logic [1:0] LP_LANDSCAPE_LEFT = 2'h3;
  localparam logic BF_FRONT = 1'b0;
  localparam logic BF_BACK = 1'b1;
  // debounce counter width
  localparam int DB_WIDTH = 8;
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_FIRST = 3'b010,
    ST_RUN = 3'b100
  } run_state_e;
endpackage

// *** verilog/orient_setup_regs.sv ***
// orientation setup and debounce threshold registers
// assumes write strobes come from the same clock domain as the block
`timescale 1ns/100ps
module orient_setup_regs
  import orient_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_setup,
  output logic [7:0] o_dbcount
);
  logic [7:0] setup;
  logic [7:0] dbcount;
  logic [7:0] next_setup;
  logic [7:0] next_dbcount;

  always_comb begin
    next_setup = setup;
    next_dbcount = dbcount;
    if (i_reg_wr && i_reg_addr == ADDR_SETUP) begin
      next_setup = i_reg_wdata;
    end
    if (i_reg_wr && i_reg_addr == ADDR_DBCOUNT) begin
      next_dbcount = i_reg_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      setup <= SETUP_RESET;
      dbcount <= DBCOUNT_RESET;
    end else begin
      setup <= next_setup;
      dbcount <= next_dbcount;
    end
  end

  assign o_setup = setup;
  assign o_dbcount = dbcount;
endmodule

// *** verilog/orient_debounce.sv ***
// orientation debounce counter with decrement or clear on a differing sample
// assumes the caller gates i_sample with enable, standby and over-range
`timescale 1ns/100ps
module orient_debounce #(
  parameter int WIDTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clr,
  input wire logic i_sample,
  input wire logic i_new_differs,
  input wire logic i_cand_differs,
  input wire logic i_mode_clear,
  input wire logic [WIDTH-1:0] i_threshold,
  output logic [WIDTH-1:0] o_count,
  output logic o_accept
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic [WIDTH:0] count_inc;

  assign count_inc = {1'b0, count} + {{WIDTH{1'b0}}, 1'b1};
  // zero threshold accepts even a sample that just changed
  assign o_accept = i_sample && i_cand_differs &&
    (i_threshold == '0 || (!i_new_differs && count_inc >= {1'b0, i_threshold}));

  always_comb begin
    next_count = count;
    if (i_clr) begin
      next_count = '0;
    end else if (i_sample) begin
      if (o_accept) begin
        next_count = '0;
      end else if (i_new_differs) begin
        if (i_mode_clear) begin
          next_count = '0;
        end else if (count != '0) begin
          next_count = count - 1'b1;
        end
      end else if (i_cand_differs) begin
        next_count = count_inc[WIDTH-1:0];
      end else begin
        next_count = '0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign o_count = count;
endmodule

// *** verilog/orient_detect_status.sv ***
// orientation detection status: debounced orientation report, change flag, registers
// assumes a front end delivers one classified orientation per output sample period
// Function
// - the change flag drives the orientation_event_source output and the state register shows the new state
// - bit 7 is set after the first detection after activation and on any tilt, back/front or landscape/portrait change
// - a read of the orientation_state_register clears the change flag unless an orientation is accepted in the same cycle
// - a rising change flag pulses the auto-wake/sleep timer clear
// - bit 6 shows whether the z-tilt lockout angle is exceeded
// - bits 2 to 1 give portrait up, portrait down, landscape right, landscape left as 00 to 11
// - bit 0 gives front as 0 and back as 1
// - the orientation fields keep updating while the change flag stays set
// - back/front and landscape/portrait read 0 after reset and after each activation
// - the orientation result holds while any axis is above 1.25 g
// - the debounce counter freezes while any axis is above 1.25 g
// - a sample differing from the previous one decrements the counter in mode 0 or clears it in mode 1
// - detection runs only with setup bit 6 set, which resets to 0
// - a new orientation is accepted only after persisting for the debounce count
// - the counter advances once per output sample period
// - the counter resets on activation, deactivation and on a wake/sleep change
`timescale 1ns/100ps
module orient_detect_status
  import orient_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_active,
  input wire logic i_wake,
  input wire logic i_sample_valid,
  input wire logic i_over_range,
  input wire logic i_sample_tilt,
  input wire logic [1:0] i_sample_lp,
  input wire logic i_sample_bf,
  output logic [7:0] o_reg_rdata,
  output logic o_orient_event,
  output logic o_aslp_timer_clear
);
  import orient_pkg::*;

  logic [7:0] setup;
  logic [7:0] debounce_threshold;
  logic [DB_WIDTH-1:0] db_count;
  logic db_accept;

  run_state_e run_state;
  run_state_e next_run_state;
  logic orientation_change_flag;
  logic next_flag;
  logic z_tilt_exceeded_flag;
  logic next_tilt;
  logic [1:0] landscape_portrait_state;
  logic [1:0] next_lp;
  logic back_front_state;
  logic next_bf;
  logic [3:0] prev_sample;
  logic [3:0] next_prev_sample;
  logic prev_active;
  logic prev_wake;
  logic aslp_clear;
  logic next_aslp_clear;
  logic [7:0] rdata;
  logic [7:0] next_rdata;

  logic orientation_detect_on;
  logic debounce_mode_bit;
  logic act_rise;
  logic act_fall;
  logic wake_change;
  logic db_clr;
  logic proc;
  logic [3:0] sample;
  logic [3:0] reported;
  logic state_read;

  orient_setup_regs u_setup_regs (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_setup(setup),
    .o_dbcount(debounce_threshold)
  );

  assign orientation_detect_on = setup[ENABLE_BIT];
  assign debounce_mode_bit = setup[MODE_BIT];
  assign act_rise = i_active && !prev_active;
  assign act_fall = !i_active && prev_active;
  assign wake_change = i_wake != prev_wake;
  // a disabled function keeps its counter parked at zero
  assign db_clr = act_rise || act_fall || wake_change || !orientation_detect_on;
  // over-range samples are skipped whole, so both counter and result hold
  assign proc = i_sample_valid && !i_over_range && !db_clr && run_state != ST_STANDBY;
  assign sample = {i_sample_tilt, i_sample_lp, i_sample_bf};
  assign reported = {z_tilt_exceeded_flag, landscape_portrait_state, back_front_state};
  assign state_read = i_reg_rd && i_reg_addr == ADDR_STATE;

  orient_debounce #(
    .WIDTH(DB_WIDTH)
  ) u_debounce (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clr(db_clr),
    .i_sample(proc),
    .i_new_differs(sample != prev_sample),
    .i_cand_differs(sample != reported || run_state == ST_FIRST),
    .i_mode_clear(debounce_mode_bit),
    .i_threshold(debounce_threshold),
    .o_count(db_count),
    .o_accept(db_accept)
  );

  always_comb begin
    next_run_state = run_state;
    next_tilt = z_tilt_exceeded_flag;
    next_lp = landscape_portrait_state;
    next_bf = back_front_state;
    next_flag = orientation_change_flag;
    next_prev_sample = prev_sample;
    case (run_state)
      ST_STANDBY: begin
        if (act_rise) begin
          next_run_state = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (act_fall) begin
          next_run_state = ST_STANDBY;
        end else if (db_accept) begin
          next_run_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (act_fall) begin
          next_run_state = ST_STANDBY;
        end else if (act_rise) begin
          next_run_state = ST_FIRST;
        end
      end
      default: begin
        next_run_state = ST_STANDBY;
      end
    endcase
    // read clear first so a same-cycle detection still sets the flag
    if (state_read) begin
      next_flag = 1'b0;
    end
    if (proc) begin
      next_prev_sample = sample;
    end
    if (db_accept) begin
      next_tilt = i_sample_tilt;
      next_lp = i_sample_lp;
      next_bf = i_sample_bf;
      next_flag = 1'b1;
    end
    if (act_rise) begin
      next_lp = LP_PORTRAIT_UP;
      next_bf = BF_FRONT;
    end
  end

  always_comb begin
    next_aslp_clear = next_flag && !orientation_change_flag;
    next_rdata = rdata;
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_STATE: begin
          next_rdata = {orientation_change_flag, z_tilt_exceeded_flag, 3'h0,
                        landscape_portrait_state, back_front_state};
        end
        ADDR_SETUP: begin
          next_rdata = setup;
        end
        ADDR_DBCOUNT: begin
          next_rdata = debounce_threshold;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      run_state <= ST_STANDBY;
      orientation_change_flag <= STATE_RESET[FLAG_BIT];
      z_tilt_exceeded_flag <= STATE_RESET[TILT_BIT];
      landscape_portrait_state <= STATE_RESET[LP_HI:LP_LO];
      back_front_state <= STATE_RESET[BF_BIT];
      prev_sample <= 4'h0;
      // follow the inputs in reset so release brings no false edge
      prev_active <= i_active;
      prev_wake <= i_wake;
      aslp_clear <= 1'b0;
      rdata <= 8'h00;
    end else begin
      run_state <= next_run_state;
      orientation_change_flag <= next_flag;
      z_tilt_exceeded_flag <= next_tilt;
      landscape_portrait_state <= next_lp;
      back_front_state <= next_bf;
      prev_sample <= next_prev_sample;
      prev_active <= i_active;
      prev_wake <= i_wake;
      aslp_clear <= next_aslp_clear;
      rdata <= next_rdata;
    end
  end

  assign o_orient_event = orientation_change_flag;
  assign o_aslp_timer_clear = aslp_clear;
  assign o_reg_rdata = rdata;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  event_source_a: assert property ($rose(o_orient_event) |-> $past(db_accept))
    else $error("event rose without an accepted orientation");
  flag_set_a: assert property (db_accept |=> o_orient_event)
    else $error("accepted orientation did not set change flag");
  flag_clear_a: assert property (state_read && !db_accept |=> !o_orient_event)
    else $error("state read did not clear change flag");
  timer_clear_a: assert property ($rose(o_orient_event) |-> o_aslp_timer_clear)
    else $error("rising flag without timer clear pulse");
  timer_only_a: assert property (o_aslp_timer_clear |-> $rose(o_orient_event))
    else $error("timer clear pulse without rising flag");
  state_read_a: assert property (state_read ##1 1 |-> o_reg_rdata[6:0] ==
      $past({z_tilt_exceeded_flag, 3'h0, landscape_portrait_state, back_front_state}))
    else $error("state read data does not match fields");
  field_follow_a: assert property (db_accept && !act_rise |=>
      {z_tilt_exceeded_flag, landscape_portrait_state, back_front_state} == $past(sample))
    else $error("accepted orientation not reported");
  activate_zero_a: assert property ($rose(i_active) |=>
      landscape_portrait_state == 2'h0 && !back_front_state)
    else $error("fields not cleared on activation");
  range_hold_a: assert property (i_over_range && !db_clr |=> $stable(db_count) &&
      $stable({z_tilt_exceeded_flag, landscape_portrait_state, back_front_state}))
    else $error("result or counter moved while over range");
  mode_clear_a: assert property (proc && debounce_mode_bit && sample != prev_sample &&
      !db_accept |=> db_count == 8'h00)
    else $error("clear mode did not clear counter");
  mode_decr_a: assert property (proc && !debounce_mode_bit && sample != prev_sample &&
      !db_accept && db_count != 8'h00 |=> db_count == $past(db_count) - 8'h01)
    else $error("decrement mode did not decrement");
  disabled_a: assert property (!orientation_detect_on |=> db_count == 8'h00 &&
      !$rose(o_orient_event))
    else $error("disabled function still active");
  persist_a: assert property (db_accept && debounce_threshold > 8'h01 |->
      {1'b0, db_count} + 9'h001 >= {1'b0, debounce_threshold})
    else $error("orientation accepted before debounce count");
  per_sample_a: assert property (!i_sample_valid && !db_clr |=> $stable(db_count))
    else $error("counter moved without a sample");
  wake_reset_a: assert property (i_wake != $past(i_wake) |=> db_count == 8'h00)
    else $error("counter not reset on wake change");
  flag_report_a: assert property (state_read |=>
      o_reg_rdata[FLAG_BIT] == $past(o_orient_event))
    else $error("read data lost the change flag");
  flag_hold_a: assert property (o_orient_event && !state_read |=> o_orient_event)
    else $error("change flag dropped without a read");
  no_false_set_a: assert property (!o_orient_event && !db_accept |=> !o_orient_event)
    else $error("change flag set without an accepted orientation");
  tilt_keep_a: assert property (act_rise |=> $stable(z_tilt_exceeded_flag))
    else $error("activation disturbed the tilt flag");
  disabled_hold_a: assert property (!orientation_detect_on && !act_rise |=>
      $stable(reported))
    else $error("fields moved while disabled");
  deact_clear_a: assert property (act_fall |=>
      db_count == 8'h00 && run_state == ST_STANDBY)
    else $error("deactivation did not park the counter");
  act_start_a: assert property (act_rise |=>
      db_count == 8'h00 && run_state == ST_FIRST)
    else $error("activation did not restart detection");
  first_accept_a: assert property (run_state == ST_FIRST && db_accept |=>
      run_state == ST_RUN && o_orient_event)
    else $error("first detection after activation not flagged");
  timer_single_a: assert property (o_aslp_timer_clear |=> !o_aslp_timer_clear)
    else $error("timer clear longer than one cycle");
  zero_threshold_a: assert property (proc && debounce_threshold == 8'h00 &&
      (sample != reported || run_state == ST_FIRST) |-> db_accept)
    else $error("zero threshold did not accept at once");
  count_step_a: assert property (proc && !db_accept && sample == prev_sample &&
      (sample != reported || run_state == ST_FIRST) |=> db_count == $past(db_count) + 8'h01)
    else $error("steady sample did not advance the counter");
  settle_zero_a: assert property (proc && run_state == ST_RUN &&
      sample == reported && sample == prev_sample |=> db_count == 8'h00)
    else $error("counter not cleared on the reported orientation");
  setup_read_a: assert property (i_reg_rd && i_reg_addr == ADDR_SETUP |=>
      o_reg_rdata == $past(setup))
    else $error("setup read data wrong");
  range_prev_a: assert property (i_over_range |=> $stable(prev_sample))
    else $error("over-range sample was recorded");
  rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");

  first_detect_c: cover property (run_state == ST_FIRST ##1 run_state == ST_RUN);
  read_collide_c: cover property (state_read && db_accept);
  range_freeze_c: cover property (i_over_range && i_sample_valid && orientation_detect_on);
  decrement_c: cover property (proc && !debounce_mode_bit && sample != prev_sample);
  wake_clear_c: cover property (wake_change && db_count != 8'h00);
endmodule

// *** tb/test_orientation_detect_status.sv ***
// self-checking bench for the orientation detection status block
// assumes inputs driven on falling edges, one sample stream, threshold kept small
`timescale 1ns/100ps
module test_orientation_detect_status;
  import orient_pkg::*;
  typedef struct {logic [3:0] orient; logic [7:0] status;} row_s;
  logic i_sys_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'h0;
  logic i_reg_rd = 1'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_active = 1'h0;
  logic i_wake = 1'h0;
  logic i_sample_valid = 1'h0;
  logic i_over_range = 1'h0;
  logic i_sample_tilt = 1'h0;
  logic [1:0] i_sample_lp = 2'h0;
  logic i_sample_bf = 1'h0;
  logic [7:0] o_reg_rdata;
  logic o_orient_event;
  logic o_aslp_timer_clear;
  int mismatches = 0;
  int total_checks = 0;
  int pulses = 0;
  int cycles = 0;
  logic [7:0] rdata_seen;
  // orientation packed as {tilt, lp, bf}; each row differs from the one before
  row_s rows [4] = '{'{4'h8, 8'hC0}, '{4'h3, 8'h83}, '{4'hE, 8'hC6}, '{4'h5, 8'h85}};

  orient_detect_status dut_u (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata),
    .i_active(i_active),
    .i_wake(i_wake),
    .i_sample_valid(i_sample_valid),
    .i_over_range(i_over_range),
    .i_sample_tilt(i_sample_tilt),
    .i_sample_lp(i_sample_lp),
    .i_sample_bf(i_sample_bf),
    .o_reg_rdata(o_reg_rdata),
    .o_orient_event(o_orient_event),
    .o_aslp_timer_clear(o_aslp_timer_clear)
  );

  initial begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // whole run is a few hundred cycles; ceiling leaves ample margin
  always @(posedge i_sys_clk) begin
    cycles = cycles + 1;
    if (o_aslp_timer_clear === 1'h1) begin
      pulses = pulses + 1;
    end
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      results();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ev(input logic exp);
    check({7'h00, o_orient_event}, {7'h00, exp});
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_sys_clk);
    i_reg_wr = 1'h1;
    i_reg_addr = addr;
    i_reg_wdata = data;
    @(negedge i_sys_clk);
    i_reg_wr = 1'h0;
  endtask

  task automatic reg_read(input logic [7:0] addr);
    @(negedge i_sys_clk);
    i_reg_rd = 1'h1;
    i_reg_addr = addr;
    @(negedge i_sys_clk);
    i_reg_rd = 1'h0;
    @(negedge i_sys_clk);
    rdata_seen = o_reg_rdata;
  endtask

  // back-to-back samples, then one spare edge so an accept has landed
  task automatic send(input int n, input logic [3:0] orient, input logic over);
    for (int i = 0; i < n; i++) begin
      @(negedge i_sys_clk);
      i_sample_valid = 1'h1;
      {i_sample_tilt, i_sample_lp, i_sample_bf} = orient;
      i_over_range = over;
    end
    @(negedge i_sys_clk);
    i_sample_valid = 1'h0;
    i_over_range = 1'h0;
    @(negedge i_sys_clk);
  endtask

  task automatic defaults;
    reg_read(ADDR_STATE);
    check(rdata_seen, STATE_RESET);
    reg_read(ADDR_SETUP);
    check(rdata_seen, SETUP_RESET);
    reg_read(ADDR_DBCOUNT);
    check(rdata_seen, DBCOUNT_RESET);
    reg_read(8'h30);
    check(rdata_seen, 8'h00);
    ev(1'h0);
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge i_sys_clk);
    i_rst = 1'h0;
    defaults();
    reg_write(ADDR_SETUP, 8'h3F);
    reg_read(ADDR_SETUP);
    check(rdata_seen, 8'h3F);
    reg_write(ADDR_DBCOUNT, 8'hA5);
    reg_read(ADDR_DBCOUNT);
    check(rdata_seen, 8'hA5);
    reg_write(ADDR_STATE, 8'hFF);
    reg_read(ADDR_STATE);
    check(rdata_seen, 8'h00);
    end_test("registers");
    i_active = 1'h1;
    send(5, 4'h5, 1'h0);
    ev(1'h0);
    reg_read(ADDR_STATE);
    check(rdata_seen, 8'h00);
    end_test("disabled");
    reg_write(ADDR_DBCOUNT, 8'h03);
    reg_write(ADDR_SETUP, 8'hC0);
    send(4, 4'h5, 1'h0);
    ev(1'h1);
    reg_read(ADDR_STATE);
    check(rdata_seen, 8'h85);
    reg_read(ADDR_STATE);
    check(rdata_seen, 8'h05);
    ev(1'h0);
    end_test("first detection");
    foreach (rows[i]) begin
      send(3, rows[i].orient, 1'h0);
      ev(1'h0);
      send(1, rows[i].orient, 1'h0);
      ev(1'h1);
      reg_read(ADDR_STATE);
      check(rdata_seen, rows[i].status);
      reg_read(ADDR_STATE);
      check(rdata_seen, rows[i].status & 8'h7F);
    end
    end_test("orientation rows");
    // count carried into mode 0; a changing sample then only steps it down
    send(2, 4'hA, 1'h0);
    reg_write(ADDR_SETUP, 8'h40);
    send(1, 4'hA, 1'h0);
    send(2, 4'h7, 1'h0);
    ev(1'h0);
    send(1, 4'h7, 1'h0);
    ev(1'h1);
    reg_read(ADDR_STATE);
    check(rdata_seen, 8'h87);
    reg_write(ADDR_SETUP, 8'hC0);
    end_test("decrement mode");
    send(2, 4'h9, 1'h0);
    send(4, 4'h6, 1'h1);
    send(1, 4'h9, 1'h0);
    ev(1'h0);
    reg_read(ADDR_STATE);
    check(rdata_seen, 8'h07);
    send(1, 4'h9, 1'h0);
    ev(1'h1);
    send(4, 4'h2, 1'h0);
    reg_read(ADDR_STATE);
    check(rdata_seen, 8'h82);
    end_test("over range");
    send(3, 4'hC, 1'h0);
    i_wake = 1'h1;
    send(1, 4'hC, 1'h0);
    ev(1'h0);
    send(3, 4'hC, 1'h0);
    ev(1'h1);
    reg_read(ADDR_STATE);
    check(rdata_seen, 8'hC4);
    end_test("wake change");
    i_active = 1'h0;
    repeat (3) @(negedge i_sys_clk);
    i_active = 1'h1;
    reg_read(ADDR_STATE);
    check(rdata_seen & 8'h07, 8'h00);
    send(4, 4'h8, 1'h0);
    ev(1'h1);
    reg_read(ADDR_STATE);
    check(rdata_seen, 8'hC0);
    end_test("reactivation");
    reg_write(ADDR_SETUP, 8'h80);
    send(5, 4'hF, 1'h0);
    ev(1'h0);
    reg_read(ADDR_STATE);
    check(rdata_seen, 8'h40);
    check(8'(pulses), 8'h09);
    end_test("disable again");
    i_rst = 1'h1;
    repeat (5) @(negedge i_sys_clk);
    i_rst = 1'h0;
    defaults();
    end_test("second reset");
    results();
  end
endmodule
